/* scg_sleep_gate.sv */
// sleep controller and peripheral clock gating with an APB register port
// assumes core, interrupt controller and peripherals on clk_sys, and the
// interrupt controller doing priority and vectoring on its own
`timescale 1ns/10ps
`include "scg_consts.svh"
module scg_sleep_gate
#(
    parameter logic [9:0] PRESENT = 10'h3FF // peripherals built in
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [7:0]   paddr,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         sleep_instr,
    input  wire logic         irq_any,
    input  wire logic         irq_port_async,
    input  wire logic         irq_addr_match,
    input  wire logic         irq_rtc,
    input  wire logic         rtc_enabled,
    input  wire logic         nvm_busy,
    output logic              cpu_halt,
    output logic              cpu_clk_en,
    output logic              nvm_clk_en,
    output logic              sys_osc_run,
    output logic              rtc_osc_run,
    output logic              wake_pulse,
    output logic [9:0]        periph_clk_en,
    output scg_pkg::scg_state_t power_state
);
    import scg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // true for the five defined mode codes
    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = (m == SCG_IDLE) || (m == SCG_DEEP_HALT) ||
                  (m == SCG_COUNTER_KEPT) || (m == SCG_OSC_KEPT) ||
                  (m == SCG_EXT_OSC_KEPT);
    endfunction

    // counter kept modes keep the real-time counter alive
    function automatic logic rtc_mode(input logic [2:0] m);
        rtc_mode = (m == SCG_COUNTER_KEPT) || (m == SCG_EXT_OSC_KEPT);
    endfunction

    // oscillator kept modes keep the system sources
    function automatic logic osc_mode(input logic [2:0] m);
        osc_mode = (m == SCG_OSC_KEPT) || (m == SCG_EXT_OSC_KEPT);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]  sleep_control;          // arm bit and mode field
    logic [7:0]  general_clock_gate;     // counter and routing gates
    logic [7:0]  analog_port_clock_gate; // converter and comparator
    logic [7:0]  digital_port_clock_gate; // timers and serial blocks
    scg_state_t  state;                  // power state
    scg_state_t  next_state;             // its next value
    logic [2:0]  sleep_mode_select;      // mode latched at entry
    logic [1:0]  hold_cnt;               // cycles spent in hold
    logic        wake_hit;               // allowed wake source seen
    logic        enter;                  // armed sleep with legal mode
    logic        bus_wr;                 // write completes this edge
    logic        bus_rd;                 // read answered next edge
    logic        hit;                    // address is mapped
    logic [7:0]  rd_byte;                // read mux
    logic [9:0]  gates;                  // gate bits per peripheral
    logic        per_on;                 // peripheral domain running
    logic        rtc_on;                 // counter domain running

    wire logic       sleep_arm = sleep_control[`SCG_ARM_BIT];
    wire logic [2:0] ctl_mode  = sleep_control[`SCG_MODE_MSB:`SCG_MODE_LSB];

    ////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer in second access cycle

    assign bus_rd = psel && penable && !pready;
    assign bus_wr = psel && penable && pready && pwrite;

    // address decode and read mux
    always_comb
    begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            `SCG_OFF_CTRL: rd_byte = sleep_control;
            `SCG_OFF_GEN:  rd_byte = general_clock_gate;
            `SCG_OFF_ANA:  rd_byte = analog_port_clock_gate;
            `SCG_OFF_DIG:  rd_byte = digital_port_clock_gate;
            `SCG_OFF_STAT: rd_byte = {3'h0, sleep_mode_select, state};
            default:       hit = 1'b0;
        endcase
    end

    // pready pulses for one cycle per access
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= bus_rd;
            pslverr <= bus_rd && !hit;
            // unmapped reads answer zero with an error
            prdata  <= bus_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // register writes; reserved bits are never stored
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sleep_control           <= `SCG_REG_RST;
            general_clock_gate      <= `SCG_REG_RST;
            analog_port_clock_gate  <= `SCG_REG_RST;
            digital_port_clock_gate <= `SCG_REG_RST;
        end
        else if (bus_wr)
        begin
            case (paddr)
                `SCG_OFF_CTRL: sleep_control <= pwdata[7:0] & `SCG_CTRL_MASK;
                `SCG_OFF_GEN:  general_clock_gate <= pwdata[7:0] & `SCG_GEN_MASK;
                `SCG_OFF_ANA:  analog_port_clock_gate <= pwdata[7:0] & `SCG_ANA_MASK;
                `SCG_OFF_DIG:  digital_port_clock_gate <= pwdata[7:0] & `SCG_DIG_MASK;
                default:       ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sleep sequencing

    // armed and legal code; reserved codes make the instruction a no-op
    assign enter = sleep_instr && sleep_arm && mode_ok(ctl_mode);

    // wake sources allowed by the latched mode
    always_comb
    begin
        case (sleep_mode_select)
            SCG_IDLE:
                wake_hit = irq_any;
            SCG_COUNTER_KEPT, SCG_EXT_OSC_KEPT:
                wake_hit = irq_port_async || irq_addr_match ||
                           (irq_rtc && rtc_enabled);
            default:
                wake_hit = irq_port_async || irq_addr_match;
        endcase
    end

    // state transitions
    always_comb
    begin
        next_state = state;
        case (state)
            SCG_ACTIVE:
                if (enter)
                    next_state = SCG_ASLEEP;
            SCG_ASLEEP:
                // interrupt stays pending; controller serves it by priority
                if (wake_hit)
                    next_state = SCG_HOLD;
            SCG_HOLD:
                if (hold_cnt == `SCG_HOLD_LAST)
                    next_state = SCG_ACTIVE;
            default:
                next_state = SCG_ACTIVE;
        endcase
    end

    // state register; reset in sleep restarts awake, registers cleared
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            state <= SCG_ACTIVE;
        else
            state <= next_state;
    end

    // mode latched at entry so a stray write cannot shift it
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sleep_mode_select <= SCG_IDLE;
        else if (state == SCG_ACTIVE && enter)
            sleep_mode_select <= ctl_mode;
    end

    // hold counter, zero on entry
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            hold_cnt <= 2'h0;
        else if (state == SCG_HOLD)
            hold_cnt <= hold_cnt + 2'h1;
        else
            hold_cnt <= 2'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // clock domains; next-state based so outputs track the state

    logic [2:0] nm;  // mode seen by the output flops
    logic       nsl; // going to be asleep
    assign nm  = (state == SCG_ACTIVE) ? ctl_mode : sleep_mode_select;
    assign nsl = (next_state == SCG_ASLEEP);

    // peripheral domain only in active, hold and idle
    assign per_on = !nsl || (nm == SCG_IDLE);
    assign rtc_on = per_on || (rtc_mode(nm) && rtc_enabled);

    // gate bits in peripheral index order; absent ones masked off
    assign gates = {digital_port_clock_gate[6], digital_port_clock_gate[4:0],
                    analog_port_clock_gate[1:0], general_clock_gate[2:1]}
                   & PRESENT;

    // clock enables; a gated peripheral keeps its flops frozen
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cpu_halt      <= 1'b0;
            cpu_clk_en    <= 1'b1;
            nvm_clk_en    <= 1'b1;
            sys_osc_run   <= 1'b1;
            rtc_osc_run   <= 1'b1;
            wake_pulse    <= 1'b0;
            periph_clk_en <= 10'h3FF;
            power_state   <= SCG_ACTIVE;
        end
        else
        begin
            cpu_halt    <= (next_state != SCG_ACTIVE);
            cpu_clk_en  <= !nsl;
            // programming in progress is let finish
            nvm_clk_en  <= !nsl || nvm_busy;
            sys_osc_run <= !nsl || (nm == SCG_IDLE) || osc_mode(nm);
            rtc_osc_run <= rtc_on;
            wake_pulse  <= (state == SCG_ASLEEP) && wake_hit;
            power_state <= next_state;
            for (int i = 0; i < `SCG_NPER; i++)
            begin
                // clearing a gate restores the clock, state untouched
                if (i == `SCG_P_RTC)
                    periph_clk_en[i] <= rtc_on && !gates[i];
                else
                    periph_clk_en[i] <= per_on && !gates[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_wake;
        state == SCG_ASLEEP && wake_hit;
    endsequence

    sequence s_hold4;
        (state == SCG_HOLD)[*4] ##1 state == SCG_ACTIVE;
    endsequence

    property p_unarmed;
        @(posedge clk_sys) disable iff (!rst_n)
        (state == SCG_ACTIVE && sleep_instr && !sleep_arm) |=> state == SCG_ACTIVE;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("slept while unarmed");

    property p_reserved;
        @(posedge clk_sys) disable iff (!rst_n)
        (state == SCG_ACTIVE && sleep_instr && sleep_arm && !mode_ok(ctl_mode))
        |=> state == SCG_ACTIVE && !cpu_halt;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode slept");

    property p_enter;
        @(posedge clk_sys) disable iff (!rst_n)
        (state == SCG_ACTIVE && enter) |=> state == SCG_ASLEEP
        && sleep_mode_select == $past(ctl_mode);
    endproperty
    a_enter: assert property (p_enter) else $error("armed sleep not entered");

    property p_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        s_wake |=> s_hold4;
    endproperty
    a_hold: assert property (p_hold) else $error("hold not four cycles");

    property p_halted;
        @(posedge clk_sys) disable iff (!rst_n)
        state == SCG_ASLEEP |-> cpu_halt && !cpu_clk_en;
    endproperty
    a_halted: assert property (p_halted) else $error("core runs asleep");

    property p_idle_wake;
        @(posedge clk_sys) disable iff (!rst_n)
        (s_wake ##0 sleep_mode_select == SCG_IDLE) |=> wake_pulse;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake lost");

    property p_deep_rtc;
        @(posedge clk_sys) disable iff (!rst_n)
        (state == SCG_ASLEEP && sleep_mode_select == SCG_DEEP_HALT && irq_rtc
         && !irq_port_async && !irq_addr_match) |=> state == SCG_ASLEEP;
    endproperty
    a_deep_rtc: assert property (p_deep_rtc) else $error("counter woke deep halt");

    property p_per_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (state == SCG_ASLEEP && sleep_mode_select != SCG_IDLE)
        |-> (periph_clk_en & ~(10'h001 << `SCG_P_RTC)) == 10'h000
        && nvm_clk_en == $past(nvm_busy);
    endproperty
    a_per_off: assert property (p_per_off) else $error("peripheral clock in sleep");

    property p_standby;
        @(posedge clk_sys) disable iff (!rst_n)
        (state == SCG_ASLEEP && sleep_mode_select == SCG_OSC_KEPT)
        |-> sys_osc_run && !periph_clk_en[`SCG_P_RTC];
    endproperty
    a_standby: assert property (p_standby) else $error("standby clocks wrong");

    property p_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        ($past(general_clock_gate[1]) && PRESENT[`SCG_P_ROUTING])
        |-> !periph_clk_en[`SCG_P_ROUTING];
    endproperty
    a_gate: assert property (p_gate) else $error("gated clock runs");

    property p_rsvd_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        pready && $past(paddr) == `SCG_OFF_DIG |-> prdata[7] == 1'b0
        && prdata[5] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read one");
endmodule

/* scg_consts.svh */
// register offsets, field layout, reset values and counts of the sleep and
// clock gating block; assumes an APB slave with 32-bit data, 8-bit registers
`ifndef SCG_CONSTS_SVH
`define SCG_CONSTS_SVH
`define SCG_OFF_CTRL     8'h00
`define SCG_OFF_GEN      8'h04
`define SCG_OFF_ANA      8'h08
`define SCG_OFF_DIG      8'h0C
`define SCG_OFF_STAT     8'h10
`define SCG_CTRL_MASK    8'h0F
`define SCG_GEN_MASK     8'h06
`define SCG_ANA_MASK     8'h03
`define SCG_DIG_MASK     8'h5F
`define SCG_REG_RST      8'h00
`define SCG_ARM_BIT      0
`define SCG_MODE_LSB     1
`define SCG_MODE_MSB     3
`define SCG_HOLD_LAST    2'h3
`define SCG_NPER         10
`define SCG_P_ROUTING    0
`define SCG_P_RTC        1
`endif

/* scg_pkg.sv */
// types of the sleep and clock gating block
// assumes nothing beyond a SystemVerilog compiler
package scg_pkg;
    // power state; gray along active, asleep, hold
    typedef enum logic [1:0]
    {
        SCG_ACTIVE = 2'h0,
        SCG_ASLEEP = 2'h1,
        SCG_HOLD   = 2'h3
    } scg_state_t;
    // sleep mode codes of the control register
    typedef enum logic [2:0]
    {
        SCG_IDLE          = 3'h0,
        SCG_DEEP_HALT     = 3'h2,
        SCG_COUNTER_KEPT  = 3'h3,
        SCG_OSC_KEPT      = 3'h6,
        SCG_EXT_OSC_KEPT  = 3'h7
    } scg_mode_t;
endpackage

/* scg_core_model.sv */
// stand-in for the core and the interrupt controller beside the sleep block
// assumes the bench pulses sleep_req and irq_set right after a rising edge
`timescale 1ns/10ps
module scg_core_model
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       cpu_halt,
    input  wire logic       sleep_req,
    input  wire logic [3:0] irq_set,
    output logic            sleep_instr,
    output logic            irq_any,
    output logic            irq_port_async,
    output logic            irq_addr_match,
    output logic            irq_rtc
);
    logic [3:0] pend; // pending: generic, port, two-wire, counter
    ////////////////////////////////////////////////////////////////////////
    // a halted core executes nothing, so no sleep instruction then
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sleep_instr <= 1'b0;
        else
            sleep_instr <= sleep_req & ~cpu_halt;
    end
    // requests stay pending until the running core services them
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            pend <= 4'h0;
        else
            pend <= (pend & {4{cpu_halt}}) | irq_set;
    end
    assign irq_any        = |pend;
    assign irq_port_async = pend[1];
    assign irq_addr_match = pend[2];
    assign irq_rtc        = pend[3];
endmodule

/* sleep_and_clock_gating_bench.sv */
// self-checking bench of the sleep and clock gating block
// assumes the core model file is compiled first
`timescale 1ns/10ps
`include "scg_consts.svh"
module sleep_and_clock_gating_bench;
    import scg_pkg::*;
    localparam logic [9:0] PRES = 10'h1FF; // two-wire left out of the build
    localparam logic [7:0] OFFS [4] = '{`SCG_OFF_CTRL, `SCG_OFF_GEN,
                                        `SCG_OFF_ANA, `SCG_OFF_DIG};
    localparam logic [7:0] MASK [4] = '{8'h0F, 8'h06, 8'h03, 8'h5F};
    localparam logic [7:0] GOFF [10] = '{`SCG_OFF_GEN, `SCG_OFF_GEN,
        `SCG_OFF_ANA, `SCG_OFF_ANA, `SCG_OFF_DIG, `SCG_OFF_DIG,
        `SCG_OFF_DIG, `SCG_OFF_DIG, `SCG_OFF_DIG, `SCG_OFF_DIG};
    localparam int GBIT [10] = '{1, 2, 0, 1, 0, 1, 2, 3, 4, 6};
    localparam logic [2:0] MD [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
    localparam int WK [5] = '{0, 1, 3, 2, 3}; // wake request per mode
    localparam int BAD [5] = '{0, 3, 0, 3, 0}; // ignored request per mode
    localparam logic SYS [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    localparam logic RTC [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    localparam logic [9:0] PER [5] = '{10'h1EF, 10'h000, 10'h002, 10'h000, 10'h002};
    logic        clk_sys;
    logic        rst_n;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sleep_instr;
    logic        sleep_req;
    logic [3:0]  irq_set;
    logic        irq_any;
    logic        irq_port_async;
    logic        irq_addr_match;
    logic        irq_rtc;
    logic        rtc_enabled;
    logic        nvm_busy;
    logic        cpu_halt;
    logic        cpu_clk_en;
    logic        nvm_clk_en;
    logic        sys_osc_run;
    logic        rtc_osc_run;
    logic        wake_pulse;
    logic [9:0]  periph_clk_en;
    scg_state_t  power_state;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    scg_sleep_gate #(.PRESENT(PRES)) scg_sleep_gate_inst
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_instr(sleep_instr),
        .irq_any(irq_any), .irq_port_async(irq_port_async),
        .irq_addr_match(irq_addr_match), .irq_rtc(irq_rtc),
        .rtc_enabled(rtc_enabled), .nvm_busy(nvm_busy), .cpu_halt(cpu_halt),
        .cpu_clk_en(cpu_clk_en), .nvm_clk_en(nvm_clk_en),
        .sys_osc_run(sys_osc_run), .rtc_osc_run(rtc_osc_run),
        .wake_pulse(wake_pulse), .periph_clk_en(periph_clk_en),
        .power_state(power_state)
    );
    scg_core_model scg_core_model_inst
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .cpu_halt(cpu_halt),
        .sleep_req(sleep_req), .irq_set(irq_set), .sleep_instr(sleep_instr),
        .irq_any(irq_any), .irq_port_async(irq_port_async),
        .irq_addr_match(irq_addr_match), .irq_rtc(irq_rtc)
    );
    ////////////////////////////////////////////////////////////////////////
    // free-running 20 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // settle one time unit past the edge so registered outputs have landed
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        // pready is read at the edge itself, before that edge updates it
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            mismatches++;
            $display("MISMATCH t=%0t no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, x);
        check(32'(e), 32'(xe));
    endtask
    task automatic do_sleep;
        @(posedge clk_sys);
        sleep_req <= 1'b1;
        @(posedge clk_sys);
        sleep_req <= 1'b0;
        step(3);
    endtask
    task automatic pulse_irq(input int k);
        @(posedge clk_sys);
        irq_set <= 4'h1 << k;
        @(posedge clk_sys);
        irq_set <= 4'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reset values, reserved bits and an unmapped address
    task automatic t_regs;
        for (int i = 0; i < 4; i++)
        begin
            rd_chk(OFFS[i], 32'h0, 1'b0);
            wr(OFFS[i], 8'hFF);
            rd_chk(OFFS[i], 32'(MASK[i]), 1'b0);
            wr(OFFS[i], 8'h00);
        end
        rd_chk(`SCG_OFF_STAT, 32'h0, 1'b0);
        rd_chk(8'h14, 32'h0, 1'b1);
    endtask
    // each present peripheral's gate bit stops exactly it, then releases it; the absent one's gate does nothing
    task automatic t_gate;
        logic b;
        for (int i = 0; i < 9; i++)
        begin
            // nothing runs in the model peripherals, so gating is safe
            wr(GOFF[i], 8'h01 << GBIT[i]);
            step(2);
            check(32'(periph_clk_en & PRES), 32'(PRES & ~(10'h001 << i)));
            wr(GOFF[i], 8'h00);
            step(2);
            check(32'(periph_clk_en & PRES), 32'(PRES));
        end
        b = periph_clk_en[9];
        wr(`SCG_OFF_DIG, 8'h40);
        step(2);
        check(32'(periph_clk_en[9]), 32'(b));
        rd_chk(`SCG_OFF_DIG, 32'h40, 1'b0);
        wr(`SCG_OFF_DIG, 8'h00);
    endtask
    // disarmed and reserved codes never sleep
    task automatic t_refuse;
        logic [7:0] c [4] = '{8'h00, 8'h03, 8'h09, 8'h0B};
        for (int i = 0; i < 4; i++)
        begin
            wr(`SCG_OFF_CTRL, c[i]);
            do_sleep();
            check(32'(power_state), 32'(SCG_ACTIVE));
            check(32'(cpu_halt), 32'h0);
        end
        wr(`SCG_OFF_CTRL, 8'h00);
    endtask
    // every mode: domains, a wrong wake source except in idle, the right one, hold time
    task automatic t_modes;
        int n;
        rtc_enabled <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            nvm_busy <= (i == 0);
            wr(`SCG_OFF_DIG, 8'h01);
            wr(`SCG_OFF_CTRL, {4'h0, MD[i], 1'b1});
            do_sleep();
            check(32'(power_state), 32'(SCG_ASLEEP));
            check(32'(cpu_clk_en), 32'h0);
            check(32'(nvm_clk_en), 32'(i == 0));
            check(32'(sys_osc_run), 32'(SYS[i]));
            check(32'(rtc_osc_run), 32'(RTC[i]));
            check(32'(periph_clk_en & PRES), 32'(PER[i]));
            if (i != 0)
            begin
                pulse_irq(BAD[i]);
                step(4);
                check(32'(power_state), 32'(SCG_ASLEEP));
            end
            pulse_irq(WK[i]);
            n = 0;
            while (wake_pulse !== 1'b1 && n < 10)
            begin
                step(1);
                n++;
            end
            check(32'(wake_pulse), 32'h1);
            check(32'(power_state), 32'(SCG_HOLD));
            step(3);
            check(32'(wake_pulse), 32'h0);
            check(32'(cpu_halt), 32'h1);
            step(1);
            check(32'(power_state), 32'(SCG_ACTIVE));
            check(32'(cpu_halt), 32'h0);
            wr(`SCG_OFF_CTRL, 8'h00);
            rd_chk(`SCG_OFF_DIG, 32'h01, 1'b0);
            wr(`SCG_OFF_DIG, 8'h00);
        end
    endtask
    // a reset in deep sleep restarts with registers cleared
    task automatic t_reset;
        wr(`SCG_OFF_CTRL, 8'h05);
        do_sleep();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        step(1);
        check(32'(power_state), 32'(SCG_ACTIVE));
        check(32'(cpu_halt), 32'h0);
        rd_chk(`SCG_OFF_CTRL, 32'h0, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        sleep_req = 1'b0;
        irq_set = 4'h0;
        rtc_enabled = 1'b0;
        nvm_busy = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_gate();
        t_refuse();
        t_modes();
        t_reset();
        print_verdict();
    end
endmodule
